// ===== core/csr_pkg.sv
package csr_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [3:0] BAUD_4800 = 4'h0;
  localparam logic [3:0] BAUD_9600 = 4'h1;
  localparam logic [3:0] BAUD_14400 = 4'h2;
  localparam logic [3:0] BAUD_19200 = 4'h3;
  localparam logic [3:0] BAUD_38400 = 4'h4;
  localparam logic [3:0] BAUD_56000 = 4'h5;
  localparam logic [3:0] BAUD_57600 = 4'h6;
  localparam logic [3:0] BAUD_115200 = 4'h7;
  localparam logic [3:0] BAUD_128000 = 4'h8;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ODD = 2'h1;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] ROUTE_FOLLOWS_VIDEO_SOURCE = 2'h0;
  localparam logic [1:0] ROUTE_FIRST_CONNECTOR = 2'h1;
  localparam logic [1:0] ROUTE_SECOND_CONNECTOR = 2'h2;
  localparam logic [3:0] RST_BIT_RATE = BAUD_9600;
  localparam logic RST_CHAR_SIZE = 1'b1;
  localparam logic [1:0] RST_PARITY = PARITY_NONE;
  localparam logic [1:0] RST_CONNECTOR = ROUTE_FOLLOWS_VIDEO_SOURCE;
  localparam logic [1:0] IDX_CONFIG = 2'h0;
  localparam logic [1:0] IDX_STATUS = 2'h1;
  localparam logic [1:0] IDX_TX_DATA = 2'h2;
  localparam logic [1:0] IDX_RX_DATA = 2'h3;
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_SIZE_BIT = 4;
  localparam int CFG_PAR_LSB = 5;
  localparam int CFG_STOP_BIT = 7;
  localparam int CFG_SEL_LSB = 8;
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_PAR_ERR = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_ACTIVE_CON = 5;
  localparam logic [3:0] DATA_BITS_7 = 4'h7;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  typedef enum logic [2:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_PARITY,
    SER_STOP
  } csr_phase_type;
endpackage : csr_pkg

// ===== core/csr_router.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module csr_router (
  input wire logic CLK_SYS_I, // 20 MHz system clock
  input wire logic RST_I, // Asynchronous reset, active high
  input wire logic HSEL_I, // AHB slave select
  input wire logic [31:0] HADDR_I, // AHB address
  input wire logic [1:0] HTRANS_I, // AHB transfer type
  input wire logic HWRITE_I, // AHB write
  input wire logic [2:0] HSIZE_I, // AHB size, word only
  input wire logic [31:0] HWDATA_I, // AHB write data
  input wire logic HREADY_I, // AHB bus ready
  output logic [31:0] HRDATA_O, // AHB read data
  output logic HREADYOUT_O, // AHB slave ready
  output logic HRESP_O, // AHB response, always OKAY
  input wire logic VIDEO_SRC_SECOND_I, // Video source is on second connector
  input wire logic CON1_RX_I, // Receive line, first connector
  input wire logic CON2_RX_I, // Receive line, second connector
  output logic CON1_TX_O, // Transmit line, first connector
  output logic CON2_TX_O // Transmit line, second connector
);
  import csr_pkg::*;

  typedef struct packed {
    logic [3:0] serial_bit_rate;
    logic serial_char_size;
    logic [1:0] parity_mode;
    logic [1:0] serial_connector_select;
    logic route_second;
    logic vsrc_s1;
    logic vsrc_s2;
    logic rx1_s1;
    logic rx1_s2;
    logic rx2_s1;
    logic rx2_s2;
    logic dph_write;
    logic [1:0] dph_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    csr_phase_type tx_phase;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_line;
    logic con1_tx;
    logic con2_tx;
    csr_phase_type rx_phase;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_valid;
    logic par_err;
    logic frame_err;
    logic overrun;
  } csr_state_type;

  csr_state_type s_reg;
  csr_state_type s_next;

  // Cycles per bit for each rate code; unknown codes fall back to 9600
  function automatic logic [15:0] bit_cycles(input logic [3:0] code);
    int unsigned baud;
    case (code)
      BAUD_4800: baud = 4800;
      BAUD_14400: baud = 14400;
      BAUD_19200: baud = 19200;
      BAUD_38400: baud = 38400;
      BAUD_56000: baud = 56000;
      BAUD_57600: baud = 57600;
      BAUD_115200: baud = 115200;
      BAUD_128000: baud = 128000;
      default: baud = 9600;
    endcase
    return 16'((CLK_HZ + baud / 2) / baud);
  endfunction : bit_cycles

  function automatic logic [3:0] data_bits(input logic size8);
    return size8 ? DATA_BITS_8 : DATA_BITS_7;
  endfunction : data_bits

  // Parity bit to send, or expected, for the given data
  function automatic logic parity_of(input logic [7:0] d, input logic size8,
                                     input logic [1:0] mode);
    logic p;
    p = ^{d[7] & size8, d[6:0]};
    return (mode == PARITY_ODD) ? ~p : p;
  endfunction : parity_of

  logic [15:0] div;
  logic rx_line;
  logic want_second;
  logic addr_ok;

  always_comb begin
    s_next = s_reg;
    div = bit_cycles(s_reg.serial_bit_rate);
    rx_line = s_reg.route_second ? s_reg.rx2_s2 : s_reg.rx1_s2;
    addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
    s_next.vsrc_s1 = VIDEO_SRC_SECOND_I;
    s_next.vsrc_s2 = s_reg.vsrc_s1;
    s_next.rx1_s1 = CON1_RX_I;
    s_next.rx1_s2 = s_reg.rx1_s1;
    s_next.rx2_s1 = CON2_RX_I;
    s_next.rx2_s2 = s_reg.rx2_s1;
    s_next.hreadyout = 1'b1;
    s_next.hresp = 1'b0;

    // Route choice; only changed between characters so no frame is split
    case (s_reg.serial_connector_select)
      ROUTE_FIRST_CONNECTOR: want_second = 1'b0;
      ROUTE_SECOND_CONNECTOR: want_second = 1'b1;
      default: want_second = s_reg.vsrc_s2;
    endcase
    if (s_reg.tx_phase == SER_IDLE && s_reg.rx_phase == SER_IDLE) begin
      s_next.route_second = want_second;
    end

    // Transmitter
    s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
    case (s_reg.tx_phase)
      SER_IDLE: begin
        s_next.tx_line = 1'b1;
        s_next.tx_cnt = s_reg.tx_cnt;
      end
      SER_START: begin
        s_next.tx_line = 1'b0;
        if (s_reg.tx_cnt == 16'h0000) begin
          s_next.tx_phase = SER_DATA;
          s_next.tx_cnt = div - 16'h0001;
          s_next.tx_bit = 4'h1;
          s_next.tx_line = s_reg.tx_shift[0];
        end
      end
      SER_DATA: begin
        if (s_reg.tx_cnt == 16'h0000) begin
          s_next.tx_cnt = div - 16'h0001;
          if (s_reg.tx_bit == data_bits(s_reg.serial_char_size)) begin
            if (s_reg.parity_mode == PARITY_NONE) begin
              s_next.tx_phase = SER_STOP;
              s_next.tx_line = 1'b1;
            end else begin
              s_next.tx_phase = SER_PARITY;
              s_next.tx_line = parity_of(s_reg.tx_shift, s_reg.serial_char_size,
                                         s_reg.parity_mode);
            end
          end else begin
            s_next.tx_bit = s_reg.tx_bit + 4'h1;
            s_next.tx_line = s_reg.tx_shift[s_reg.tx_bit[2:0]];
          end
        end
      end
      SER_PARITY: begin
        if (s_reg.tx_cnt == 16'h0000) begin
          s_next.tx_phase = SER_STOP;
          s_next.tx_cnt = div - 16'h0001;
          s_next.tx_line = 1'b1;
        end
      end
      SER_STOP: begin
        // Single stop bit
        if (s_reg.tx_cnt == 16'h0000) begin
          s_next.tx_phase = SER_IDLE;
        end
      end
      default: s_next.tx_phase = SER_IDLE;
    endcase
    // Unselected connector rests idle high
    s_next.con1_tx = s_reg.route_second ? 1'b1 : s_reg.tx_line;
    s_next.con2_tx = s_reg.route_second ? s_reg.tx_line : 1'b1;

    // Receiver
    s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
    case (s_reg.rx_phase)
      SER_IDLE: begin
        s_next.rx_cnt = {1'b0, div[15:1]};
        if (!rx_line) begin
          s_next.rx_phase = SER_START;
        end
      end
      SER_START: begin
        if (s_reg.rx_cnt == 16'h0000) begin
          s_next.rx_cnt = div - 16'h0001;
          s_next.rx_bit = 4'h0;
          s_next.rx_shift = 8'h00;
          s_next.rx_phase = rx_line ? SER_IDLE : SER_DATA;
        end
      end
      SER_DATA: begin
        if (s_reg.rx_cnt == 16'h0000) begin
          s_next.rx_cnt = div - 16'h0001;
          s_next.rx_shift[s_reg.rx_bit[2:0]] = rx_line;
          s_next.rx_bit = s_reg.rx_bit + 4'h1;
          if (s_reg.rx_bit + 4'h1 == data_bits(s_reg.serial_char_size)) begin
            s_next.rx_phase = (s_reg.parity_mode == PARITY_NONE) ? SER_STOP : SER_PARITY;
          end
        end
      end
      SER_PARITY: begin
        if (s_reg.rx_cnt == 16'h0000) begin
          s_next.rx_cnt = div - 16'h0001;
          s_next.rx_phase = SER_STOP;
          if (rx_line != parity_of(s_reg.rx_shift, s_reg.serial_char_size,
                                   s_reg.parity_mode)) begin
            s_next.par_err = 1'b1;
          end
        end
      end
      SER_STOP: begin
        if (s_reg.rx_cnt == 16'h0000) begin
          s_next.rx_phase = SER_IDLE;
          s_next.rx_data = s_reg.rx_shift;
          if (!rx_line) begin
            s_next.frame_err = 1'b1;
          end
          if (s_reg.rx_valid) begin
            s_next.overrun = 1'b1;
          end
        end
      end
      default: s_next.rx_phase = SER_IDLE;
    endcase

    // Bus: reads answered from the address phase, writes done in data phase
    // Address range is judged in the address phase; HADDR_I is stale in the data phase
    s_next.dph_write = addr_ok & HWRITE_I & (HADDR_I[31:4] == 28'h0000000);
    s_next.dph_idx = HADDR_I[3:2];
    if (addr_ok && !HWRITE_I) begin
      s_next.hrdata = 32'h00000000;
      if (HADDR_I[31:4] == 28'h0000000) begin
        case (HADDR_I[3:2])
          IDX_CONFIG: begin
            s_next.hrdata[CFG_RATE_LSB +: 4] = s_reg.serial_bit_rate;
            s_next.hrdata[CFG_SIZE_BIT] = s_reg.serial_char_size;
            s_next.hrdata[CFG_PAR_LSB +: 2] = s_reg.parity_mode;
            s_next.hrdata[CFG_SEL_LSB +: 2] = s_reg.serial_connector_select;
          end
          IDX_STATUS: begin
            s_next.hrdata[ST_TX_BUSY] = (s_reg.tx_phase != SER_IDLE);
            s_next.hrdata[ST_RX_VALID] = s_reg.rx_valid;
            s_next.hrdata[ST_PAR_ERR] = s_reg.par_err;
            s_next.hrdata[ST_FRAME_ERR] = s_reg.frame_err;
            s_next.hrdata[ST_OVERRUN] = s_reg.overrun;
            s_next.hrdata[ST_ACTIVE_CON] = s_reg.route_second;
          end
          IDX_RX_DATA: begin
            s_next.hrdata[7:0] = s_reg.rx_data;
            s_next.rx_valid = 1'b0;
          end
          default: s_next.hrdata = 32'h00000000;
        endcase
      end
    end
    if (s_reg.dph_write) begin
      case (s_reg.dph_idx)
        IDX_CONFIG: begin
          s_next.serial_bit_rate = HWDATA_I[CFG_RATE_LSB +: 4];
          s_next.serial_char_size = HWDATA_I[CFG_SIZE_BIT];
          s_next.parity_mode = HWDATA_I[CFG_PAR_LSB +: 2];
          s_next.serial_connector_select = HWDATA_I[CFG_SEL_LSB +: 2];
        end
        IDX_STATUS: begin
          // Write one to clear; a new error in the same cycle wins below
          if (HWDATA_I[ST_PAR_ERR]) s_next.par_err = 1'b0;
          if (HWDATA_I[ST_FRAME_ERR]) s_next.frame_err = 1'b0;
          if (HWDATA_I[ST_OVERRUN]) s_next.overrun = 1'b0;
        end
        IDX_TX_DATA: begin
          if (s_reg.tx_phase == SER_IDLE) begin
            s_next.tx_phase = SER_START;
            s_next.tx_cnt = div - 16'h0001;
            s_next.tx_shift = HWDATA_I[7:0];
            s_next.tx_line = 1'b0;
          end
        end
        default: s_next.tx_shift = s_next.tx_shift;
      endcase
    end
    // Hardware sets win over software clears
    if (s_reg.rx_phase == SER_STOP && s_reg.rx_cnt == 16'h0000) begin
      s_next.rx_valid = 1'b1;
      if (!rx_line) s_next.frame_err = 1'b1;
      if (s_reg.rx_valid) s_next.overrun = 1'b1;
    end
    if (s_reg.rx_phase == SER_PARITY && s_reg.rx_cnt == 16'h0000 &&
        rx_line != parity_of(s_reg.rx_shift, s_reg.serial_char_size, s_reg.parity_mode)) begin
      s_next.par_err = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      s_reg <= '0;
      s_reg.serial_bit_rate <= RST_BIT_RATE;
      s_reg.serial_char_size <= RST_CHAR_SIZE;
      s_reg.parity_mode <= RST_PARITY;
      s_reg.serial_connector_select <= RST_CONNECTOR;
      s_reg.vsrc_s1 <= 1'b0;
      s_reg.rx1_s1 <= 1'b1;
      s_reg.rx1_s2 <= 1'b1;
      s_reg.rx2_s1 <= 1'b1;
      s_reg.rx2_s2 <= 1'b1;
      s_reg.hreadyout <= 1'b1;
      s_reg.tx_phase <= SER_IDLE;
      s_reg.rx_phase <= SER_IDLE;
      s_reg.tx_line <= 1'b1;
      s_reg.con1_tx <= 1'b1;
      s_reg.con2_tx <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign HRDATA_O = s_reg.hrdata;
  assign HREADYOUT_O = s_reg.hreadyout;
  assign HRESP_O = s_reg.hresp;
  assign CON1_TX_O = s_reg.con1_tx;
  assign CON2_TX_O = s_reg.con2_tx;
endmodule : csr_router

// ===== tb/csr_router_sva.sv
`timescale 1ns/10ps
module csr_router_sva (
  input wire logic CLK_SYS_I, // Clock
  input wire logic RST_I, // Reset
  input wire logic HSEL_I, // Select
  input wire logic [1:0] HTRANS_I, // Transfer type
  input wire logic HWRITE_I, // Write
  input wire logic HREADY_I, // Bus ready
  input wire logic [31:0] HRDATA_O, // Read data
  input wire logic HREADYOUT_O, // Slave ready
  input wire logic HRESP_O, // Response
  input wire logic CON1_TX_O, // First transmit line
  input wire logic CON2_TX_O // Second transmit line
);
  logic rd_take;
  logic [15:0] low_cnt;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  assign rd_take = HSEL_I & HTRANS_I[1] & HREADY_I & ~HWRITE_I;
  // Longest legal low run is ten bit times at the slowest rate
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) low_cnt <= 16'h0;
    else low_cnt <= (CON1_TX_O & CON2_TX_O) ? 16'h0 : low_cnt + 16'h1;
  end
  a_ready_high: assert property (HREADYOUT_O)
    else $error("hready low");
  a_resp_okay: assert property (!HRESP_O)
    else $error("error response");
  a_rdata_hold: assert property (!$past(rd_take) |-> $stable(HRDATA_O))
    else $error("read data moved");
  a_one_line: assert property (CON1_TX_O || CON2_TX_O)
    else $error("both lines active");
  a_start_first: assert property ($fell(CON1_TX_O) |-> !CON1_TX_O[*8])
    else $error("short start bit first");
  a_start_second: assert property ($fell(CON2_TX_O) |-> !CON2_TX_O[*8])
    else $error("short start bit second");
  a_bit_min: assert property ($rose(CON1_TX_O) |-> CON1_TX_O[*8])
    else $error("short high bit");
  a_stop_seen: assert property (low_cnt < 16'ha2e4)
    else $error("no stop bit");
  cover property ($fell(CON1_TX_O));
  cover property ($fell(CON2_TX_O));
  cover property (rd_take ##1 HREADYOUT_O);
endmodule : csr_router_sva

// ===== tb/csr_cam_model.sv
`timescale 1ns/10ps
module csr_cam_model (
  input wire logic clk_i, // Bit timing clock
  input wire logic line_i, // Line from the device
  output logic line_o, // Line to the device
  input wire logic [3:0] nbits_i, // Data bits
  input wire logic [1:0] par_i, // Parity mode
  input wire logic [31:0] bit_i // Bit time in clocks
);
  import csr_pkg::*;
  logic [7:0] got;
  logic par_ok;
  logic stop_ok;
  int n_got = 0;
  int t_start;
  initial line_o = 1'b1;
  function automatic logic par_of(input logic [7:0] d);
    logic p;
    p = ^(nbits_i == DATA_BITS_8 ? d : {1'b0, d[6:0]});
    return (par_i == PARITY_ODD) ? ~p : p;
  endfunction : par_of
  always begin : rx_char
    @(negedge line_i);
    t_start = 0;
    while (line_i === 1'b0) begin
      @(posedge clk_i);
      t_start++;
    end
    repeat (bit_i / 2) @(posedge clk_i);
    got = 8'h00;
    for (int i = 0; i < nbits_i; i++) begin
      got[i] = line_i;
      repeat (bit_i) @(posedge clk_i);
    end
    par_ok = (par_i == PARITY_NONE) || (line_i === par_of(got));
    if (par_i != PARITY_NONE) repeat (bit_i) @(posedge clk_i);
    stop_ok = (line_i === 1'b1);
    n_got++;
  end
  task automatic send(input logic [7:0] c, input logic bad_par, input logic bad_stop);
    line_o <= 1'b0;
    repeat (bit_i) @(posedge clk_i);
    for (int i = 0; i < nbits_i; i++) begin
      line_o <= c[i];
      repeat (bit_i) @(posedge clk_i);
    end
    if (par_i != PARITY_NONE) begin
      line_o <= par_of(c) ^ bad_par;
      repeat (bit_i) @(posedge clk_i);
    end
    line_o <= ~bad_stop;
    repeat (bit_i) @(posedge clk_i);
    line_o <= 1'b1;
  endtask : send
endmodule : csr_cam_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("Error %s exp %h got %h", nm, e, g); fails++; end end
module tb_top;
  import csr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwr = 1'b0, vid2 = 1'b0;
  logic [1:0] htr = 2'h0;
  logic [31:0] hadr = 32'h0, hwd = 32'h0, hrd, rd;
  logic hro, hresp, rx1, rx2, tx1, tx2;
  logic [3:0] nb = 4'h8;
  logic [1:0] par = 2'h0;
  logic [31:0] seed = 32'hdd1e0cc7;
  int bt = 2083, fails = 0, n_compared = 0;
  always #25 clk = ~clk;
  csr_router u_dut (.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(hadr),
    .HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hro),
    .HRDATA_O(hrd), .HREADYOUT_O(hro), .HRESP_O(hresp), .VIDEO_SRC_SECOND_I(vid2),
    .CON1_RX_I(rx1), .CON2_RX_I(rx2), .CON1_TX_O(tx1), .CON2_TX_O(tx2));
  csr_cam_model u_cam1 (.clk_i(clk), .line_i(tx1), .line_o(rx1), .nbits_i(nb),
    .par_i(par), .bit_i(bt));
  csr_cam_model u_cam2 (.clk_i(clk), .line_i(tx2), .line_o(rx2), .nbits_i(nb),
    .par_i(par), .bit_i(bt));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int cyc_of(input logic [3:0] rc);
    int baud [9] = '{4800, 9600, 14400, 19200, 38400, 56000, 57600, 115200, 128000};
    return (CLK_HZ + baud[rc] / 2) / baud[rc];
  endfunction : cyc_of
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic wait_rdy;
    int k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hro !== 1'b1 && k < 20);
    if (hro !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask : wait_rdy
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    hadr <= a;
    htr <= 2'h2;
    hwr <= w;
    wait_rdy();
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    wait_rdy();
    rd = hrd;
  endtask : bus
  task automatic poll(input int b, input logic v);
    int k = 0;
    do begin
      bus(32'h4, 1'b0, 32'h0);
      k++;
    end while (rd[b] !== v && k < 10000);
    `CHK("status wait", v, rd[b])
    if (rd[b] !== v) conclude();
  endtask : poll
  task automatic tx_one(input logic [3:0] rc, input logic [1:0] sel, input logic [1:0] p,
                        input logic b8, input logic cfg);
    logic [7:0] c;
    logic sec;
    int n1, n2, t;
    seed = lfsr(seed);
    c = seed[7:0] | 8'h01;
    nb = b8 ? DATA_BITS_8 : DATA_BITS_7;
    par = p;
    bt = cyc_of(rc);
    if (cfg) bus(32'h0, 1'b1, {22'h0, sel, 1'b0, p, b8, rc});
    n1 = u_cam1.n_got;
    n2 = u_cam2.n_got;
    bus(32'h8, 1'b1, {24'h0, c});
    sec = (sel == ROUTE_SECOND_CONNECTOR) || (sel == ROUTE_FOLLOWS_VIDEO_SOURCE && vid2);
    poll(ST_TX_BUSY, 1'b0);
    `CHK("active con", sec, rd[ST_ACTIVE_CON])
    `CHK("frames first", n1 + (sec ? 0 : 1), u_cam1.n_got)
    `CHK("frames second", n2 + (sec ? 1 : 0), u_cam2.n_got)
    `CHK("char", c & (b8 ? 8'hff : 8'h7f), sec ? u_cam2.got : u_cam1.got)
    `CHK("parity", 1'b1, sec ? u_cam2.par_ok : u_cam1.par_ok)
    `CHK("stop", 1'b1, sec ? u_cam2.stop_ok : u_cam1.stop_ok)
    t = sec ? u_cam2.t_start : u_cam1.t_start;
    `CHK("bit time", 1'b1, t >= bt - 1 && t <= bt + 1)
  endtask : tx_one
  task automatic rx_one(input logic bp, input logic bs, input logic sec);
    logic [7:0] c;
    seed = lfsr(seed);
    c = seed[7:0];
    if (sec) u_cam2.send(c, bp, bs);
    else u_cam1.send(c, bp, bs);
    bus(32'h4, 1'b0, 32'h0);
    if (!bp && !bs) `CHK("rx valid", !sec, rd[ST_RX_VALID])
    `CHK("parity err", bp, rd[ST_PAR_ERR])
    `CHK("frame err", bs, rd[ST_FRAME_ERR])
    bus(32'hc, 1'b0, 32'h0);
    if (!(bp | bs | sec)) `CHK("rx char", {24'h0, c}, rd)
    bus(32'h4, 1'b1, 32'h1c);
  endtask : rx_one
  initial begin
    #5000000;
    fails++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(32'h0, 1'b0, 32'h0);
    `CHK("config", {22'h0, RST_CONNECTOR, 1'b0, RST_PARITY, RST_CHAR_SIZE, RST_BIT_RATE}, rd)
    tx_one(RST_BIT_RATE, RST_CONNECTOR, RST_PARITY, RST_CHAR_SIZE, 1'b0);
    for (int r = 2; r <= 8; r++) begin
      vid2 <= r[1];
      tx_one(4'(r), 2'(r % 3), 2'((r + 1) % 3), r[0], 1'b1);
    end
    nb = DATA_BITS_8;
    par = PARITY_EVEN;
    bt = cyc_of(BAUD_128000);
    bus(32'h0, 1'b1, {22'h0, ROUTE_FIRST_CONNECTOR, 1'b0, PARITY_EVEN, 1'b1, BAUD_128000});
    rx_one(1'b0, 1'b0, 1'b0);
    rx_one(1'b1, 1'b0, 1'b0);
    rx_one(1'b0, 1'b0, 1'b1);
    rx_one(1'b0, 1'b1, 1'b0);
    // Two characters with no read between them must flag overrun and keep the newer one
    u_cam1.send(8'h5a, 1'b0, 1'b0);
    @(posedge clk);
    u_cam1.send(8'ha5, 1'b0, 1'b0);
    bus(32'h4, 1'b0, 32'h0);
    `CHK("overrun", 1'b1, rd[ST_OVERRUN])
    `CHK("rx valid ovr", 1'b1, rd[ST_RX_VALID])
    bus(32'hc, 1'b0, 32'h0);
    `CHK("rx last", 32'ha5, rd)
    bus(32'h4, 1'b1, 32'h1c);
    bus(32'h4, 1'b0, 32'h0);
    `CHK("overrun clr", 1'b0, rd[ST_OVERRUN])
    bus(32'h10, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    conclude();
  end
endmodule : tb_top
bind csr_router csr_router_sva u_sva (.*);
